// file: tb/ues_host.sv
// Host model that issues decoded bus commands and polls the busy flag.
`default_nettype none

// ************************************************************
// Command host
// ************************************************************
module ues_host (
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic [15:0] i_rdata,
  output logic o_valid,
  output logic o_write,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code = 8'h00;
    o_wdata = 16'h0000;
  end

  // The strobe is one cycle wide; the answer stands one cycle later.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic ack, output logic [15:0] rd);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_write = wr;
    o_code = code;
    o_wdata = wd;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    ack = i_done;
    rd = i_rdata;
  endtask

  // Polling the status byte paces word writes and waits out erase and restore.
  task automatic wait_idle();
    logic a;
    logic [15:0] r;
    for (int i = 0; i < 400; i++) begin
      xfer(1'b0, ues_pkg::CMD_COMMON, 16'h0000, a, r);
      if (r[ues_pkg::BUSY_BIT] === 1'b1) break;
    end
  endtask
endmodule // ues_host
`default_nettype wire

// file: tb/ues_top_test.sv
// Self-checking testbench of the user EEPROM store and bulk programming block.
`default_nettype none
module ues_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_reset_n, i_rst_pin_n, i_op_we, cmd_valid, cmd_write, cmd_done, cmd_nack;
  logic busy_n, alert_n, suspend, pec, ack;
  logic [7:0] cmd_code;
  logic [3:0] op_addr;
  logic [15:0] cmd_wdata, cmd_rdata, op_wdata, op_rdata, rd;
  int n_errors = 0;
  int n_tests = 0;

  ues_top #(.P_ERASE_CYC(20), .P_WORD_CYC(8)) u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rst_pin_n(i_rst_pin_n),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_code(cmd_code),
    .i_cmd_wdata(cmd_wdata), .i_op_we(i_op_we), .i_op_addr(op_addr), .i_op_wdata(op_wdata),
    .o_cmd_done(cmd_done), .o_cmd_nack(cmd_nack), .o_cmd_rdata(cmd_rdata), .o_busy_n(busy_n),
    .o_alert_low_output_n(alert_n), .o_monitor_suspend(suspend), .o_pec_required(pec),
    .o_op_rdata(op_rdata));
  ues_host u_host (
    .i_clk(i_clk), .i_done(cmd_done), .i_rdata(cmd_rdata), .o_valid(cmd_valid),
    .o_write(cmd_write), .o_code(cmd_code), .o_wdata(cmd_wdata));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    u_host.xfer(wr, code, wd, ack, rd);
  endtask

  task automatic key_read_is(input logic [15:0] exp);
    cmd(1'b0, ues_pkg::CMD_UNLOCK, 16'h0000);
    check(rd, exp);
  endtask

  task automatic unlock_rw();
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_LEAD});
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_RW_OPT});
  endtask

  task automatic op_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    i_op_we = 1'b1;
    op_addr = a;
    op_wdata = d;
    @(posedge i_clk);
    #1;
    i_op_we = 1'b0;
  endtask

  task automatic op_read_is(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    #1;
    op_addr = a;
    @(posedge i_clk);
    #1;
    check(op_rdata, exp);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_powerup();
    check({15'h0, busy_n}, 16'h0000);
    check({15'h0, suspend}, 16'h0001);
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check({15'h0, ack}, 16'h0000);
    check({15'h0, cmd_nack}, 16'h0001);
    check({15'h0, alert_n}, 16'h0000);
    cmd(1'b0, ues_pkg::CMD_COMMON, 16'h0000);
    check({15'h0, ack}, 16'h0001);
    check({15'h0, cmd_nack}, 16'h0000);
    check(rd, 16'h0000);
    u_host.wait_idle();
    check({14'h0, suspend, busy_n}, 16'h0001);
    check({15'h0, alert_n}, 16'h0001);
  endtask

  task automatic test_keys();
    logic [7:0] k2 [4];
    logic [7:0] k3 [4];
    k2 = '{ues_pkg::KEY_RW_OPT, ues_pkg::KEY_RW_PEC, ues_pkg::KEY_MFR, ues_pkg::KEY_MFR};
    k3 = '{8'h00, 8'h00, ues_pkg::KEY_RO_OPT, ues_pkg::KEY_RO_PEC};
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_LEAD});
    key_read_is(16'h002b);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_LEAD});
      cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, k2[i]});
      if (i > 1) cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, k3[i]});
      key_read_is({8'h00, (i > 1) ? k3[i] : k2[i]});
      check({15'h0, pec}, 16'(i % 2));
    end
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_LEAD});
    cmd(1'b1, ues_pkg::CMD_UNLOCK, 16'h0077);
    key_read_is(16'h0000);
    // A stray key after a finished unlock must lock as well.
    unlock_rw();
    cmd(1'b1, ues_pkg::CMD_UNLOCK, 16'h0077);
    key_read_is(16'h0000);
    unlock_rw();
    cmd(1'b1, ues_pkg::CMD_ERASE, 16'h0055);
    key_read_is(16'h0000);
    cmd(1'b0, ues_pkg::CMD_ERASE, 16'h0000);
    check(rd, 16'h0055);
    cmd(1'b1, ues_pkg::CMD_ERASE, {8'h00, ues_pkg::ERASE_KEY});
    check({15'h0, busy_n}, 16'h0001);
  endtask

  task automatic test_store_restore();
    op_write(4'h5, 16'h1234);
    cmd(1'b1, ues_pkg::CMD_STORE, 16'h0000);
    check({15'h0, busy_n}, 16'h0000);
    u_host.wait_idle();
    op_write(4'h5, 16'h0bad);
    // No channel is modelled as enabled, so a restore is safe here.
    cmd(1'b1, ues_pkg::CMD_RESTORE, 16'h0000);
    @(posedge i_clk);
    #1;
    check({15'h0, suspend}, 16'h0001);
    u_host.wait_idle();
    op_read_is(4'h5, 16'h1234);
    op_write(4'h5, 16'h0bad);
    i_rst_pin_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_pin_n = 1'b1;
    repeat (5) @(posedge i_clk);
    u_host.wait_idle();
    op_read_is(4'h5, 16'h1234);
  endtask

  task automatic test_bulk_write();
    unlock_rw();
    cmd(1'b1, ues_pkg::CMD_ERASE, {8'h00, ues_pkg::ERASE_KEY});
    check({15'h0, ack}, 16'h0001);
    check({15'h0, busy_n}, 16'h0000);
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check({15'h0, ack}, 16'h0000);
    u_host.wait_idle();
    cmd(1'b0, ues_pkg::CMD_ERASE, 16'h0000);
    check(rd, 16'h002b);
    // Each word is left to finish programming before the next one is sent.
    for (int i = 0; i < ues_pkg::NWORDS; i++) begin
      cmd(1'b1, ues_pkg::CMD_DATA, 16'ha500 + 16'(i));
      check({15'h0, ack}, 16'h0001);
      u_host.wait_idle();
    end
    cmd(1'b1, ues_pkg::CMD_DATA, 16'hdead);
    key_read_is(16'h0000);
    op_read_is(4'h5, 16'h1234);
  endtask

  task automatic test_bulk_read();
    unlock_rw();
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check(rd, ues_pkg::PACK_REV);
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check(rd, ues_pkg::NWORDS_W);
    for (int i = 0; i < ues_pkg::NWORDS; i++) begin
      cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
      check(rd, 16'ha500 + 16'(i));
    end
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check(rd, 16'h0000);
    key_read_is(16'h0000);
    // Read-only unlock: a word write must neither land nor move the pointer.
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_LEAD});
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_MFR});
    cmd(1'b1, ues_pkg::CMD_UNLOCK, {8'h00, ues_pkg::KEY_RO_OPT});
    cmd(1'b1, ues_pkg::CMD_DATA, 16'hbeef);
    cmd(1'b0, ues_pkg::CMD_DATA, 16'h0000);
    check(rd, ues_pkg::PACK_REV);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    i_reset_n = 1'b0;
    i_rst_pin_n = 1'b1;
    i_op_we = 1'b0;
    op_addr = 4'h0;
    op_wdata = 16'h0000;
    repeat (6) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    test_powerup();
    test_keys();
    test_store_restore();
    test_bulk_write();
    test_bulk_read();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end
endmodule // ues_top_test
`default_nettype wire

// file: verilog/ues_pkg.sv
// Constants and types for the user EEPROM store and bulk programming block.
`default_nettype none
package ues_pkg;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_UNLOCK = 8'hbd;
  localparam logic [7:0] CMD_ERASE = 8'hbe;
  localparam logic [7:0] CMD_DATA = 8'hbf;
  localparam logic [7:0] CMD_COMMON = 8'hef;
  localparam logic [7:0] KEY_LEAD = 8'h2b;
  localparam logic [7:0] KEY_RW_OPT = 8'hd4;
  localparam logic [7:0] KEY_RW_PEC = 8'hd5;
  localparam logic [7:0] KEY_MFR = 8'h91;
  localparam logic [7:0] KEY_RO_OPT = 8'he4;
  localparam logic [7:0] KEY_RO_PEC = 8'he5;
  localparam logic [7:0] ERASE_KEY = 8'h2b;
  localparam int NWORDS = 16;
  localparam logic [15:0] NWORDS_W = 16'h0010;
  // Packing revision value is arbitrary.
  localparam logic [15:0] PACK_REV = 16'h0001;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int BUSY_BIT = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CLK_NS = 4;
  localparam int T_ERASE_MS = 400;
  localparam int T_WORD_NS = 510000;
  localparam int ERASE_CYC = T_ERASE_MS * 1000000 / CLK_NS;
  localparam int WORD_CYC = (T_WORD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 20;
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_PROG = 3'h1, E_ERASE = 3'h3, E_STORE = 3'h2, E_RST = 3'h6
  } ues_eng_t;
  typedef enum logic [2:0] {
    K_LOCK = 3'h0, K_LEAD = 3'h1, K_MFR = 3'h3, K_RW = 3'h2, K_RO = 3'h6
  } ues_key_t;
endpackage
`default_nettype wire

// file: verilog/ues_top.sv
// User EEPROM store, restore and key-protected bulk programming engine.
`default_nettype none

// ************************************************************
// Word write buffer
// ************************************************************
module ues_fifo #(
  parameter int W = 20,
  parameter int D = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  assign o_in_ready = cnt_q != (AW+1)'(D);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem[rp_q];
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end
endmodule // ues_fifo

// ************************************************************
// Top level
// ************************************************************
module ues_top #(
  parameter int P_ERASE_CYC = ues_pkg::ERASE_CYC,
  parameter int P_WORD_CYC = ues_pkg::WORD_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rst_pin_n,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_op_we,
  input wire logic [3:0] i_op_addr,
  input wire logic [15:0] i_op_wdata,
  output logic o_cmd_done,
  output logic o_cmd_nack,
  output logic [15:0] o_cmd_rdata,
  output logic o_busy_n,
  output logic o_alert_low_output_n,
  output logic o_monitor_suspend,
  output logic o_pec_required,
  output logic [15:0] o_op_rdata
);
  ues_pkg::ues_eng_t eng_q, eng_d;
  ues_pkg::ues_key_t k_q, k_d;
  logic [15:0] ee [ues_pkg::NWORDS];
  logic [15:0] op [ues_pkg::NWORDS];
  logic [31:0] cnt_q;
  logic [4:0] ptr_q;
  logic [7:0] key_q;
  logic [7:0] ers_q;
  logic pin_s1_q, pin_s2_q, pin_old_q;
  logic rest_pend_q;
  logic erased_q;
  logic busy_n_q;
  logic alert_n_q;
  logic pec_q;
  logic susp_q;
  logic done_q;
  logic nack_q;
  logic [15:0] rdata_q;
  logic [15:0] oprd_q;
  logic f_rdy, f_ov;
  logic [19:0] f_out;

  // ************************************************************
  // Command decode
  // ************************************************************
  wire [7:0] b = i_cmd_wdata[7:0];
  wire is_stat = (i_cmd_code == ues_pkg::CMD_COMMON) & ~i_cmd_write;
  wire is_dwr = (i_cmd_code == ues_pkg::CMD_DATA) & i_cmd_write;
  wire eng_busy = eng_q != ues_pkg::E_IDLE;
  wire hard_busy = eng_busy & (eng_q != ues_pkg::E_PROG);
  // Word writes are posted into the buffer while a word programs; only a
  // full buffer or a long operation turns them away.
  wire blocked = is_dwr ? (hard_busy | ~f_rdy) : eng_busy;
  wire nack_now = i_cmd_valid & ~is_stat & blocked;
  wire acc = i_cmd_valid & ~nack_now;
  wire wr_key = acc & i_cmd_write & (i_cmd_code == ues_pkg::CMD_UNLOCK);
  wire wr_ers = acc & i_cmd_write & (i_cmd_code == ues_pkg::CMD_ERASE);
  wire wr_dat = acc & is_dwr;
  wire rd_dat = acc & ~i_cmd_write & (i_cmd_code == ues_pkg::CMD_DATA);
  wire c_store = acc & (i_cmd_code == ues_pkg::CMD_STORE);
  wire c_rest = acc & (i_cmd_code == ues_pkg::CMD_RESTORE);
  wire unl = (k_q == ues_pkg::K_RW) | (k_q == ues_pkg::K_RO);
  wire ers_go = wr_ers & (k_q == ues_pkg::K_RW) & (b == ues_pkg::ERASE_KEY);
  wire ers_bad = wr_ers & unl & (b != ues_pkg::ERASE_KEY);
  wire rd_ok = rd_dat & unl;
  wire rd_end = rd_ok & (ptr_q > 5'(ues_pkg::NWORDS + 1));
  wire wr_ok = wr_dat & (k_q == ues_pkg::K_RW) & erased_q;
  wire wr_full = wr_ok & (ptr_q >= 5'(ues_pkg::NWORDS));
  wire push = wr_ok & ~wr_full;
  wire lock_evt = ers_bad | rd_end | wr_full;
  wire unl_next = (k_d == ues_pkg::K_RW) | (k_d == ues_pkg::K_RO);
  wire key_done = wr_key & unl_next;
  wire pin_rise = pin_s2_q & ~pin_old_q;

  // ************************************************************
  // Unlock key sequencer
  // ************************************************************
  always_comb begin
    k_d = k_q;
    if (wr_key) begin
      case (k_q)
        ues_pkg::K_LEAD: begin
          if (b == ues_pkg::KEY_RW_OPT || b == ues_pkg::KEY_RW_PEC) begin
            k_d = ues_pkg::K_RW;
          end else if (b == ues_pkg::KEY_MFR) begin
            k_d = ues_pkg::K_MFR;
          end else if (b == ues_pkg::KEY_LEAD) begin
            k_d = ues_pkg::K_LEAD;
          end else begin
            k_d = ues_pkg::K_LOCK;
          end
        end
        ues_pkg::K_MFR: begin
          if (b == ues_pkg::KEY_RO_OPT || b == ues_pkg::KEY_RO_PEC) begin
            k_d = ues_pkg::K_RO;
          end else begin
            k_d = (b == ues_pkg::KEY_LEAD) ? ues_pkg::K_LEAD : ues_pkg::K_LOCK;
          end
        end
        default: begin
          k_d = (b == ues_pkg::KEY_LEAD) ? ues_pkg::K_LEAD : ues_pkg::K_LOCK;
        end
      endcase
    end else if (lock_evt) begin
      k_d = ues_pkg::K_LOCK;
    end
  end

  // ************************************************************
  // EEPROM engine
  // ************************************************************
  wire [31:0] lim = (eng_q == ues_pkg::E_ERASE) ? 32'(P_ERASE_CYC - 1) :
                    (eng_q == ues_pkg::E_PROG) ? 32'(P_WORD_CYC - 1) :
                    32'(ues_pkg::NWORDS - 1);
  wire last = cnt_q == lim;
  wire [3:0] step = cnt_q[3:0];

  always_comb begin
    eng_d = eng_q;
    case (eng_q)
      ues_pkg::E_IDLE: begin
        if (rest_pend_q || c_rest) begin
          eng_d = ues_pkg::E_RST;
        end else if (c_store) begin
          eng_d = ues_pkg::E_STORE;
        end else if (ers_go) begin
          eng_d = ues_pkg::E_ERASE;
        end else if (f_ov) begin
          eng_d = ues_pkg::E_PROG;
        end
      end
      ues_pkg::E_PROG, ues_pkg::E_ERASE, ues_pkg::E_STORE, ues_pkg::E_RST: begin
        if (last) begin
          eng_d = ues_pkg::E_IDLE;
        end
      end
      default: begin
        eng_d = ues_pkg::E_IDLE;
      end
    endcase
  end

  ues_fifo #(
    .W(ues_pkg::FIFO_W),
    .D(ues_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(push),
    .i_in_data({ptr_q[3:0], i_cmd_wdata}),
    .o_in_ready(f_rdy),
    .o_out_valid(f_ov),
    .o_out_data(f_out),
    .i_out_ready((eng_q == ues_pkg::E_PROG) & last)
  );

  // Bulk traffic reaches only the EEPROM array; the operating array is
  // written by the core port and by a restore.
  always_ff @(posedge i_clk) begin
    if (eng_q == ues_pkg::E_ERASE && last) begin
      for (int i = 0; i < ues_pkg::NWORDS; i++) begin
        ee[i] <= ues_pkg::ERASED_WORD;
      end
    end else if (eng_q == ues_pkg::E_STORE) begin
      ee[step] <= op[step];
    end else if (eng_q == ues_pkg::E_PROG && last) begin
      ee[f_out[19:16]] <= f_out[15:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (eng_q == ues_pkg::E_RST) begin
      op[step] <= ee[step];
    end else if (i_op_we) begin
      op[i_op_addr] <= i_op_wdata;
    end
    oprd_q <= op[i_op_addr];
  end

  // ************************************************************
  // Read data selection
  // ************************************************************
  wire [4:0] ridx = ptr_q - 5'h02;
  wire [15:0] ee_word = (ptr_q == 5'h00) ? ues_pkg::PACK_REV :
                        (ptr_q == 5'h01) ? ues_pkg::NWORDS_W : ee[ridx[3:0]];
  wire [15:0] st_word = 16'(busy_n_q) << ues_pkg::BUSY_BIT;
  wire [15:0] rd_mux =
    is_stat ? st_word :
    (i_cmd_code == ues_pkg::CMD_UNLOCK) ? ((k_q == ues_pkg::K_LOCK) ? 16'h0000 : {8'h00, key_q}) :
    (i_cmd_code == ues_pkg::CMD_ERASE) ? {8'h00, ers_q} :
    (rd_ok && !rd_end) ? ee_word : 16'h0000;

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      eng_q <= ues_pkg::E_IDLE;
      k_q <= ues_pkg::K_LOCK;
      cnt_q <= '0;
      ptr_q <= '0;
      key_q <= ues_pkg::RST_BYTE;
      ers_q <= ues_pkg::RST_BYTE;
      erased_q <= 1'b0;
      pec_q <= 1'b0;
    end else begin
      eng_q <= eng_d;
      k_q <= k_d;
      cnt_q <= (eng_d != eng_q) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      if (key_done) begin
        ptr_q <= '0;
      end else if (rd_ok && !rd_end || push) begin
        ptr_q <= ptr_q + 5'h01;
      end
      if (wr_key) begin
        key_q <= b;
      end
      if (wr_ers) begin
        ers_q <= b;
      end
      if (eng_q == ues_pkg::E_ERASE && last) begin
        erased_q <= 1'b1;
      end else if (wr_full || c_store) begin
        erased_q <= 1'b0;
      end
      if (key_done) begin
        pec_q <= (b == ues_pkg::KEY_RW_PEC) | (b == ues_pkg::KEY_RO_PEC);
      end
    end
  end

  // A restore is pending from power-up and after each release of the
  // reset pin; a new pin edge in the start cycle keeps it pending.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_old_q <= 1'b1;
      rest_pend_q <= 1'b1;
    end else begin
      pin_s1_q <= i_rst_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_old_q <= pin_s2_q;
      if (pin_rise) begin
        rest_pend_q <= 1'b1;
      end else if (eng_d == ues_pkg::E_RST) begin
        rest_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      busy_n_q <= 1'b1;
      alert_n_q <= 1'b1;
      susp_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      busy_n_q <= ~((eng_d != ues_pkg::E_IDLE) | f_ov);
      susp_q <= eng_d == ues_pkg::E_RST;
      if (nack_now) begin
        alert_n_q <= 1'b0;
      end else if (acc && is_stat) begin
        alert_n_q <= 1'b1;
      end
      done_q <= acc;
      nack_q <= nack_now;
      rdata_q <= (acc && !i_cmd_write) ? rd_mux : 16'h0000;
    end
  end

  assign o_busy_n = busy_n_q;
  assign o_alert_low_output_n = alert_n_q;
  assign o_monitor_suspend = susp_q;
  assign o_pec_required = pec_q;
  assign o_cmd_done = done_q;
  assign o_cmd_nack = nack_q;
  assign o_cmd_rdata = rdata_q;
  assign o_op_rdata = oprd_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  por_restore_a: assert property ($rose(i_reset_n) |=> eng_q == ues_pkg::E_RST)
    else $error("no restore after reset release");
  store_busy_a: assert property (eng_q == ues_pkg::E_STORE |-> !o_busy_n)
    else $error("store not reported busy");
  restore_susp_a: assert property (eng_q == ues_pkg::E_RST |-> o_monitor_suspend)
    else $error("monitoring not suspended during restore");
  ptr_reset_a: assert property (key_done |=> ptr_q == 5'h00)
    else $error("pointer not reset by unlock");
  pec_mode_a: assert property (wr_key && k_q == ues_pkg::K_LEAD && b == ues_pkg::KEY_RW_PEC
    |=> o_pec_required && k_q == ues_pkg::K_RW)
    else $error("pec mode not set by unlock");
  bad_key_a: assert property (wr_key && k_q == ues_pkg::K_RW && b != ues_pkg::KEY_LEAD
    |=> k_q == ues_pkg::K_LOCK)
    else $error("bad key did not lock");
  key_read_a: assert property (acc && !i_cmd_write && i_cmd_code == ues_pkg::CMD_UNLOCK
    && k_q == ues_pkg::K_LOCK |=> o_cmd_rdata == 16'h0000)
    else $error("locked key read not zero");
  erase_run_a: assert property (ers_go
    |=> (eng_q == ues_pkg::E_ERASE && !o_busy_n) [*2])
    else $error("erase did not start busy");
  over_read_a: assert property (rd_end |=> k_q == ues_pkg::K_LOCK && o_cmd_rdata == 16'h0000
    && o_cmd_done)
    else $error("read past end did not lock");
  busy_nack_a: assert property (i_cmd_valid && !is_stat && hard_busy
    |=> o_cmd_nack && !o_alert_low_output_n && !o_cmd_done)
    else $error("busy command not refused");
  stat_ok_a: assert property (i_cmd_valid && is_stat
    |=> o_cmd_done && o_cmd_rdata[ues_pkg::BUSY_BIT] == $past(o_busy_n))
    else $error("status read refused or wrong");
  lock_ignore_a: assert property (wr_ers && k_q == ues_pkg::K_LOCK && !eng_busy
    |=> eng_q != ues_pkg::E_ERASE)
    else $error("locked erase was obeyed");

  erase_cov_c: cover property (ers_go ##1 eng_q == ues_pkg::E_ERASE);
  fill_cov_c: cover property (wr_full);
  read_end_cov_c: cover property (rd_end);
  fifo_full_cov_c: cover property (!f_rdy);
endmodule // ues_top
`default_nettype wire
